/* core/eeprom_link_pkg.sv */
// constants and types shared by both ends of the serial eeprom link
// assumes a single 50 MHz core clock on each end and a pulled-up sda
package eeprom_link_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned WRITE_TIME_MS = 5;
  // longest time: rounds down
  localparam int unsigned WRITE_CYCLES_DEF = WRITE_TIME_MS * (CLK_HZ / 1000);
  // quarter of the scl period made by the master; least time, rounds up
  localparam int unsigned SCL_QTR_NS = 60;
  localparam int unsigned QTR_CYCLES =
    (SCL_QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // control byte and array layout
  // ----------------------------------------------------------------
  // device type code: value is arbitrary
  localparam logic [3:0] DEV_TYPE_CODE = 4'h6;
  localparam int CTRL_TYPE_POS = 4;
  localparam int CTRL_CSH_POS = 3;
  localparam int CTRL_CSL_POS = 2;
  localparam int CTRL_BLK_POS = 1;
  localparam int CTRL_RW_POS = 0;
  localparam int unsigned MEM_BYTES = 512;
  localparam int unsigned PAGE_BYTES = 16;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  typedef logic [8:0] addr_t;
  typedef logic [7:0] byte_t;

  // ----------------------------------------------------------------
  // master command port
  // ----------------------------------------------------------------
  typedef logic [3:0] reg_addr_t;
  typedef logic [15:0] reg_data_t;
  localparam reg_addr_t CMD_OFS = 4'h0;
  localparam reg_addr_t STATUS_OFS = 4'h4;
  localparam int CMD_OP_POS = 8;
  localparam logic [1:0] OP_BYTE = 2'h0;
  localparam logic [1:0] OP_START = 2'h1;
  localparam logic [1:0] OP_STOP = 2'h2;
  localparam int STAT_BUSY_POS = 0;
  localparam int STAT_ACK_POS = 1;
  localparam int STAT_OWN_POS = 2;
  localparam int STAT_IDLE_POS = 3;

  // ----------------------------------------------------------------
  // state machines
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_CTRL, ST_ADDR, ST_DATA, ST_SKIP
  } slave_state_t;
  typedef enum logic [2:0] {
    H_IDLE, H_START, H_BIT, H_ACK, H_STOP
  } host_state_t;

endpackage : eeprom_link_pkg

/* core/eeprom_link_if.sv */
// two-wire link between the master and the eeprom slave
// assumes sda has a pull-up; a low wins whenever either end enables it
`timescale 1ns/1ps
`default_nettype none

interface eeprom_link_if;
  logic scl;
  logic sda;
  logic sda_host_out;
  logic sda_host_oe;
  logic sda_dev_out;
  logic sda_dev_oe;

  // open-drain wire level
  assign sda = !((sda_host_oe && !sda_host_out) ||
                 (sda_dev_oe && !sda_dev_out));

  modport device (
    input scl,
    input sda,
    output sda_dev_out,
    output sda_dev_oe
  );
  modport host (
    output scl,
    output sda_host_out,
    output sda_host_oe,
    input sda
  );
endinterface : eeprom_link_if

`default_nettype wire

/* core/eeprom_slave.sv */
// serial eeprom slave: bus conditions, addressing, page buffer, write cycle
// assumes scl and sda come from another domain and are resynchronised here
// What this block does
// - bus idle only with both lines high
// - master starts only on an idle bus, or repeats start while it holds the bus
// - sda fall during scl high is start
// - sda rise during scl high is stop
// - one bit per scl pulse, stable high
// - receiver acknowledges each byte on ninth pulse
// - acknowledge holds sda low through high phase
// - after master nack slave releases sda
// - no acknowledge while write cycle runs
// - control byte: type, selects, block, direction
// - acknowledge only on type and select match
// - block bit becomes array address bit 8
// - direction bit one reads, zero writes; a read is acked but no data is served
// - address byte loads pointer, then data byte
// - stop after data launches timed write
// - up to fifteen more bytes buffered
// - only low four pointer bits wrap
// - protect pin high blocks writes, still acks
// - whole page rewritten, untouched bytes kept
// - master polls with write control byte
// - write cycle ends within five milliseconds
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module eeprom_slave #(
  parameter int unsigned WRITE_CYCLES = eeprom_link_pkg::WRITE_CYCLES_DEF
) (
  input wire logic CORE_CLK,
  input wire logic SRST,
  eeprom_link_if.device LINK,
  input wire logic CHIP_SELECT_PIN_HIGH,
  input wire logic CHIP_SELECT_PIN_LOW,
  input wire logic WRITE_PROTECT,
  input wire eeprom_link_pkg::addr_t MEM_ADDR,
  output logic BUSY,
  output eeprom_link_pkg::byte_t MEM_DATA
);
  import eeprom_link_pkg::*;
  localparam int CNT_W = $clog2(WRITE_CYCLES + 1);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0] pin_meta, pin_sync;
  logic scl, sda, cs_high, cs_low, protect_pin, scl_d, sda_d;
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      pin_meta <= 5'h18;
      pin_sync <= 5'h18;
    end else begin
      pin_meta <= {LINK.scl, LINK.sda, CHIP_SELECT_PIN_HIGH,
                   CHIP_SELECT_PIN_LOW, WRITE_PROTECT};
      pin_sync <= pin_meta;
    end
  end

  assign {scl, sda, cs_high, cs_low, protect_pin} = pin_sync;

  // edge history starts at the idle level so reset makes no false edge
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      {scl_d, sda_d} <= 2'b11;
    end else begin
      {scl_d, sda_d} <= {scl, sda};
    end
  end

  // ----------------------------------------------------------------
  // bus conditions
  // ----------------------------------------------------------------
  logic scl_rise, scl_fall, start_cond, stop_cond;
  assign scl_rise = scl && !scl_d;
  assign scl_fall = !scl && scl_d;
  assign start_cond = scl && scl_d && sda_d && !sda;
  assign stop_cond = scl && scl_d && !sda_d && sda;

  // ----------------------------------------------------------------
  // byte framing and acknowledge
  // ----------------------------------------------------------------
  slave_state_t state, next_state;
  logic [3:0] bit_cnt;
  logic in_ack, sda_oe, active, byte_done, ctrl_match, ack_now;
  logic busy, block_bit;
  byte_t shreg;
  addr_t ptr;
  assign active = (state == ST_CTRL) || (state == ST_ADDR) ||
                  (state == ST_DATA);
  assign byte_done = active && scl_fall && !in_ack &&
                     (bit_cnt == BYTE_BITS);

  always_comb begin
    // type and chip selects must match
    ctrl_match = (shreg[7:CTRL_TYPE_POS] == DEV_TYPE_CODE) &&
                 (shreg[CTRL_CSH_POS] == cs_high) &&
                 (shreg[CTRL_CSL_POS] == cs_low) && !busy;
    next_state = ST_SKIP;
    ack_now = 1'b0;
    unique case (state)
      ST_CTRL: begin
        if (ctrl_match) begin
          ack_now = 1'b1;
          // read goes no further in this block
          next_state = shreg[CTRL_RW_POS] ? ST_SKIP : ST_ADDR;
        end
      end
      ST_ADDR, ST_DATA: begin
        ack_now = 1'b1;
        next_state = ST_DATA;
      end
      default: begin
        next_state = ST_SKIP;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      in_ack <= 1'b0;
      sda_oe <= 1'b0;
      shreg <= 8'h00;
    end else if (start_cond || stop_cond) begin
      // released lines leave the bus idle
      state <= start_cond ? ST_CTRL : ST_IDLE;
      bit_cnt <= 4'h0;
      in_ack <= 1'b0;
      sda_oe <= 1'b0;
    end else if (scl_fall && in_ack) begin
      // sda released after the ninth pulse, even from skip
      in_ack <= 1'b0;
      sda_oe <= 1'b0;
      bit_cnt <= 4'h0;
    end else if (active) begin
      if (scl_rise && !in_ack && bit_cnt != BYTE_BITS) begin
        // one bit sampled per scl rise
        shreg <= {shreg[6:0], sda};
        bit_cnt <= bit_cnt + 4'h1;
      end else if (byte_done) begin
        // held low from scl fall to next fall
        in_ack <= 1'b1;
        sda_oe <= ack_now;
        state <= next_state;
      end
    end
  end

  assign LINK.sda_dev_out = 1'b0;
  assign LINK.sda_dev_oe = sda_oe;

  // ----------------------------------------------------------------
  // address pointer
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      block_bit <= 1'b0;
      ptr <= 9'h000;
    end else if (byte_done) begin
      if (state == ST_CTRL && ctrl_match) begin
        // block bit kept for the address
        block_bit <= shreg[CTRL_BLK_POS];
      end
      if (state == ST_ADDR) begin
        ptr <= {block_bit, shreg};
      end
      if (state == ST_DATA) begin
        ptr[3:0] <= ptr[3:0] + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // page buffer
  // ----------------------------------------------------------------
  byte_t page_buf [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] page_valid;
  logic pending, launch;
  always_ff @(posedge CORE_CLK) begin
    if (byte_done && state == ST_DATA) begin
      page_buf[ptr[3:0]] <= shreg;
    end
  end

  // mask cleared only on an accepted control byte, never while busy
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      page_valid <= '0;
    end else if (byte_done && state == ST_CTRL && ctrl_match) begin
      page_valid <= '0;
    end else if (byte_done && state == ST_DATA) begin
      page_valid[ptr[3:0]] <= 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST || start_cond || stop_cond) begin
      pending <= 1'b0;
    end else if (byte_done && state == ST_DATA) begin
      pending <= 1'b1;
    end
  end

  // stop after data launches the cycle
  // no launch without a whole data byte
  // the stop's own scl pulse has already clocked in one bit
  assign launch = stop_cond && (state == ST_DATA) && pending &&
                  (bit_cnt <= 4'h1) && !in_ack;

  // ----------------------------------------------------------------
  // self-timed write cycle
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] wait_cnt;
  logic protect, commit;
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      busy <= 1'b0;
      wait_cnt <= '0;
      protect <= 1'b0;
    end else if (launch) begin
      busy <= 1'b1;
      wait_cnt <= CNT_W'(WRITE_CYCLES - 1);
      protect <= protect_pin;
    end else if (busy) begin
      if (wait_cnt == '0) begin
        busy <= 1'b0;
      end else begin
        wait_cnt <= wait_cnt - 1'b1;
      end
    end
  end

  assign commit = busy && (wait_cnt == '0) && !protect;
  assign BUSY = busy;

  // ----------------------------------------------------------------
  // array
  // ----------------------------------------------------------------
  byte_t mem [MEM_BYTES];
  // every byte of the page is rewritten
  always_ff @(posedge CORE_CLK) begin
    if (commit) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        mem[{ptr[8:4], 4'(i)}] <= page_valid[i] ? page_buf[i]
                                                : mem[{ptr[8:4], 4'(i)}];
      end
    end
  end

  // observation port for the user side; reads are not served on the link
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      MEM_DATA <= 8'h00;
    end else begin
      MEM_DATA <= mem[MEM_ADDR];
    end
  end

endmodule : eeprom_slave

`default_nettype wire

/* core/eeprom_master.sv */
// two-wire bus master: start, byte with acknowledge, stop, by command
// assumes software drives the register port on CORE_CLK
`timescale 1ns/1ps
`default_nettype none

module eeprom_master (
  input wire logic CORE_CLK,
  input wire logic SRST,
  eeprom_link_if.host LINK,
  input wire eeprom_link_pkg::reg_addr_t REG_ADDR,
  input wire eeprom_link_pkg::reg_data_t REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output eeprom_link_pkg::reg_data_t REG_RDATA
);
  import eeprom_link_pkg::*;

  localparam int QW = $clog2(QTR_CYCLES + 1);

  // ----------------------------------------------------------------
  // sda synchroniser and quarter-bit divider
  // ----------------------------------------------------------------
  logic sda_meta;
  logic sda_sync;
  logic [QW-1:0] qtr_cnt;
  logic tick;

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
    end else begin
      sda_meta <= LINK.sda;
      sda_sync <= sda_meta;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST || tick) begin
      qtr_cnt <= QW'(QTR_CYCLES - 1);
    end else begin
      qtr_cnt <= qtr_cnt - 1'b1;
    end
  end

  assign tick = (qtr_cnt == '0);

  // ----------------------------------------------------------------
  // bit engine
  // ----------------------------------------------------------------
  host_state_t hstate;
  logic [1:0] phase;
  logic scl_out;
  logic sda_oe;
  byte_t tx;
  logic [2:0] nbit;
  logic acked;
  logic owned;
  logic bus_idle;
  logic cmd_go;
  logic [1:0] op;

  assign bus_idle = scl_out && sda_sync;
  assign op = REG_WDATA[CMD_OP_POS +: 2];
  assign cmd_go = REG_WR && (REG_ADDR == CMD_OFS) && (hstate == H_IDLE);

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      hstate <= H_IDLE;
      phase <= 2'h0;
      scl_out <= 1'b1;
      sda_oe <= 1'b0;
      tx <= 8'h00;
      nbit <= 3'h0;
      acked <= 1'b0;
      owned <= 1'b0;
    end else if (hstate == H_IDLE) begin
      if (cmd_go) begin
        tx <= REG_WDATA[7:0];
        phase <= 2'h0;
        nbit <= 3'h0;
        if (op == OP_START) begin
          hstate <= H_START;
        end else if (op == OP_STOP && owned) begin
          hstate <= H_STOP;
        end else if (op == OP_BYTE && owned) begin
          hstate <= H_BIT;
        end
      end
    end else if (tick) begin
      phase <= phase + 2'h1;
      unique case (hstate)
        H_START: begin
          unique case (phase)
            2'h0: begin
              // wait for a free bus unless already held
              if (!owned && !bus_idle) begin
                phase <= phase;
              end
              sda_oe <= 1'b0;
            end
            2'h1: scl_out <= 1'b1;
            2'h2: begin
              sda_oe <= 1'b1;
              owned <= 1'b1;
            end
            2'h3: begin
              scl_out <= 1'b0;
              hstate <= H_BIT;
            end
          endcase
        end
        H_BIT: begin
          unique case (phase)
            // data changes only with scl low
            2'h0: sda_oe <= !tx[7];
            2'h1: scl_out <= 1'b1;
            2'h2: scl_out <= 1'b1;
            2'h3: begin
              scl_out <= 1'b0;
              tx <= {tx[6:0], 1'b0};
              nbit <= nbit + 3'h1;
              if (nbit == 3'h7) begin
                hstate <= H_ACK;
              end
            end
          endcase
        end
        H_ACK: begin
          unique case (phase)
            2'h0: sda_oe <= 1'b0;
            2'h1: scl_out <= 1'b1;
            // software repeats start and byte until acked
            2'h2: acked <= !sda_sync;
            2'h3: begin
              scl_out <= 1'b0;
              hstate <= H_IDLE;
            end
          endcase
        end
        H_STOP: begin
          unique case (phase)
            2'h0: sda_oe <= 1'b1;
            2'h1: scl_out <= 1'b1;
            2'h2: sda_oe <= 1'b0;
            2'h3: begin
              owned <= 1'b0;
              hstate <= H_IDLE;
            end
          endcase
        end
        default: hstate <= H_IDLE;
      endcase
    end
  end

  assign LINK.scl = scl_out;
  assign LINK.sda_host_out = 1'b0;
  assign LINK.sda_host_oe = sda_oe;

  // ----------------------------------------------------------------
  // status read
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      REG_RDATA <= 16'h0000;
    end else if (REG_RD && REG_ADDR == STATUS_OFS) begin
      REG_RDATA <= 16'h0000;
      REG_RDATA[STAT_BUSY_POS] <= (hstate != H_IDLE);
      REG_RDATA[STAT_ACK_POS] <= acked;
      REG_RDATA[STAT_OWN_POS] <= owned;
      REG_RDATA[STAT_IDLE_POS] <= bus_idle;
    end else begin
      REG_RDATA <= 16'h0000;
    end
  end

endmodule : eeprom_master

`default_nettype wire

/* bench/eeprom_link_checker.sv */
// checker for the two-wire link joining master and slave
// assumes its inputs are the signals of the shared link interface
`timescale 1ns/1ps
`default_nettype none

module eeprom_link_checker (
  input wire logic CORE_CLK,
  input wire logic SRST,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_host_out,
  input wire logic sda_host_oe,
  input wire logic sda_dev_out,
  input wire logic sda_dev_oe
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SRST);

  // ----------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------
  // ack must outlast the whole high phase, first low cycle included;
  // the master's high phase is six core cycles, so eight is ample
  sequence ack_high_phase;
    sda_dev_oe throughout (1'b1 ##[1:8] !scl);
  endsequence

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_idle_after_reset: assert property (
    $fell(SRST) |-> scl && sda && !sda_dev_oe && !sda_host_oe)
    else $error("link not idle after reset");
  a_start_hold: assert property (
    $fell(sda) && scl |-> scl[*2])
    else $error("start condition not held with scl high");
  a_stop_idle: assert property (
    $rose(sda) && scl |-> (scl && sda)[*3])
    else $error("bus not idle after stop");
  a_bit_stable: assert property (
    $rose(scl) |-> $stable(sda)[*2])
    else $error("sda moved while scl high");
  a_scl_pulse: assert property (
    $rose(scl) |-> scl[*4])
    else $error("scl high phase too short");
  a_ack_setup: assert property (
    $rose(sda_dev_oe) |-> !scl)
    else $error("slave drove sda while scl high");
  a_ack_hold: assert property (
    $rose(scl) && sda_dev_oe |-> ack_high_phase)
    else $error("ack dropped during scl high");
  a_ack_release: assert property (
    $fell(scl) && sda_dev_oe |-> ##[1:6] !sda_dev_oe)
    else $error("slave kept sda after ack pulse");
  a_dev_pulls_low: assert property (
    sda_dev_oe |-> !sda_dev_out && !sda)
    else $error("slave enable without low level");
  a_host_pulls_low: assert property (
    sda_host_oe |-> !sda_host_out && !sda)
    else $error("master enable without low level");
endmodule : eeprom_link_checker

`default_nettype wire

/* bench/tb_top.sv */
// bench: master and slave facing each other over the link interface
// assumes the master command port and op encoding of the package
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import eeprom_link_pkg::*;
  // short write cycle so ack polling still meets a busy slave
  localparam int unsigned WR_CYC = 400;
  localparam int LIMIT = 40000;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  reg_addr_t reg_addr = '0;
  reg_data_t reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  reg_data_t reg_rdata;
  logic cs_high = 1'b1;
  logic cs_low = 1'b0;
  logic wp = 1'b0;
  addr_t mem_addr = '0;
  logic busy;
  byte_t mem_data;
  int fail_count = 0;
  int checks = 0;
  int cycles = 0;
  byte_t page [16];
  logic [8:0] mon_sh = '0;
  logic scl_q = 1'b1;
  reg_data_t st;

  eeprom_link_if u_eeprom_link_if ();
  eeprom_master u_eeprom_master (
    .CORE_CLK(core_clk), .SRST(srst), .LINK(u_eeprom_link_if.host),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_RDATA(reg_rdata));
  eeprom_slave #(.WRITE_CYCLES(WR_CYC)) u_eeprom_slave (
    .CORE_CLK(core_clk), .SRST(srst), .LINK(u_eeprom_link_if.device),
    .CHIP_SELECT_PIN_HIGH(cs_high), .CHIP_SELECT_PIN_LOW(cs_low),
    .WRITE_PROTECT(wp), .MEM_ADDR(mem_addr), .BUSY(busy),
    .MEM_DATA(mem_data));
  eeprom_link_checker u_eeprom_link_checker (
    .CORE_CLK(core_clk), .SRST(srst), .scl(u_eeprom_link_if.scl),
    .sda(u_eeprom_link_if.sda),
    .sda_host_out(u_eeprom_link_if.sda_host_out),
    .sda_host_oe(u_eeprom_link_if.sda_host_oe),
    .sda_dev_out(u_eeprom_link_if.sda_dev_out),
    .sda_dev_oe(u_eeprom_link_if.sda_dev_oe));

  always #10 core_clk = ~core_clk;

  // wire monitor: last nine bits seen at scl rises, ack bit last
  always @(posedge core_clk) begin
    scl_q <= u_eeprom_link_if.scl;
    if (u_eeprom_link_if.scl && !scl_q) begin
      mon_sh <= {mon_sh[7:0], u_eeprom_link_if.sda};
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  task automatic reg_write(input reg_addr_t a, input reg_data_t d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input reg_addr_t a, output reg_data_t d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge core_clk);
  endtask : reg_read

  // bounded poll: a hung master ends the poll after 300 status reads
  task automatic cmd(input logic [1:0] op, input byte_t b);
    int n;
    n = 0;
    reg_write(CMD_OFS, {6'h00, op, b});
    do begin
      reg_read(STATUS_OFS, st);
      n++;
    end while (st[STAT_BUSY_POS] !== 1'b0 && n < 300);
  endtask : cmd

  function automatic byte_t ctl(input logic [1:0] cs, input logic blk,
                                input logic rw);
    return {DEV_TYPE_CODE, cs, blk, rw};
  endfunction : ctl

  task automatic send(input logic [1:0] op, input byte_t b, input logic ack);
    cmd(op, b);
    check("ack", 16'(st[STAT_ACK_POS]), 16'(ack));
    check("wire bits", 16'(mon_sh), 16'({b, !ack}));
  endtask : send

  task automatic stop();
    cmd(OP_STOP, 8'h00);
    check("bus idle", 16'(st[STAT_IDLE_POS]), 16'h0001);
    check("wire idle", 16'({u_eeprom_link_if.scl, u_eeprom_link_if.sda}),
          16'h0003);
  endtask : stop

  task automatic write_seq(input logic blk, input byte_t a, input int n,
                           input byte_t d0);
    send(OP_START, ctl(2'b10, blk, 1'b0), 1'b1);
    send(OP_BYTE, a, 1'b1);
    for (int i = 0; i < n; i++) begin
      send(OP_BYTE, d0 + i[7:0], 1'b1);
    end
  endtask : write_seq

  task automatic wait_write(input logic launch);
    int n;
    n = 0;
    repeat (8) @(posedge core_clk);
    check("busy", 16'(busy), 16'(launch));
    while (busy === 1'b1 && n < WR_CYC + 20) begin
      @(posedge core_clk);
      n++;
    end
    check("write end", 16'(busy), 16'h0000);
    check("write time", 16'(n <= WR_CYC), 16'h0001);
  endtask : wait_write

  task automatic mem_check(input addr_t a, input byte_t exp);
    mem_addr <= a;
    @(posedge core_clk);
    #1 check("mem", 16'(mem_data), 16'(exp));
    @(posedge core_clk);
  endtask : mem_check

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      fail_count++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge core_clk);
    srst <= 1'b0;
    repeat (3) @(posedge core_clk);
    reg_read(STATUS_OFS, st);
    check("status", st, 16'h0008);
    check("busy", 16'(busy), 16'h0000);
    for (int i = 0; i < 4; i++) begin
      {cs_high, cs_low} <= i[1:0];
      send(OP_START, ctl(i[1:0], 1'b0, 1'b0), 1'b1);
      stop();
      send(OP_START, ctl(~i[1:0], 1'b0, 1'b0), 1'b0);
      stop();
    end
    {cs_high, cs_low} <= 2'b10;
    send(OP_START, {~DEV_TYPE_CODE, 4'h8}, 1'b0);
    stop();
    write_seq(1'b1, 8'h35, 1, 8'hA5);
    stop();
    send(OP_START, ctl(2'b10, 1'b0, 1'b0), 1'b0);
    stop();
    wait_write(1'b1);
    send(OP_START, ctl(2'b10, 1'b0, 1'b0), 1'b1);
    stop();
    mem_check(9'h135, 8'hA5);
    write_seq(1'b0, 8'h1C, 18, 8'h40);
    for (int i = 0; i < 18; i++) page[(12 + i) % 16] = 8'h40 + i[7:0];
    stop();
    wait_write(1'b1);
    for (int i = 0; i < 16; i++) mem_check({5'h01, i[3:0]}, page[i]);
    write_seq(1'b0, 8'h13, 2, 8'h99);
    page[3] = 8'h99;
    page[4] = 8'h9A;
    stop();
    wait_write(1'b1);
    for (int i = 0; i < 16; i++) mem_check({5'h01, i[3:0]}, page[i]);
    wp <= 1'b1;
    write_seq(1'b0, 8'h13, 1, 8'h55);
    stop();
    wait_write(1'b1);
    wp <= 1'b0;
    mem_check(9'h013, 8'h99);
    write_seq(1'b0, 8'h13, 1, 8'h77);
    send(OP_START, ctl(2'b10, 1'b0, 1'b1), 1'b1);
    stop();
    wait_write(1'b0);
    write_seq(1'b0, 8'h13, 0, 8'h00);
    stop();
    wait_write(1'b0);
    mem_check(9'h013, 8'h99);
    final_report();
  end
endmodule : tb_top

`default_nettype wire
